// [rtl/chg_pkg.sv]
// Constants, types and register map of the charger control and status logic.
// Assumes a 25 MHz system clock and an APB master with 32-bit data.
//
// Operation
// - Status pin low while charging, else released
// - Fault pin blinks status pin at 1 Hz
// - Fault or status change gives 256 us interrupt pulse
// - Boost needs request pin, config bit 5, no input
// - Charge needs config field 01 and enable pin low
// - Input limit is lower of resistor and register
// - Ship exit after rising edge held 2 ms
// - Autonomous cycle picks precharge, CC or CV phase
// - CV phase terminates below termination current
// - Recharge starts below recharge threshold
// - Thermistor out of window suspends charge and boost
// - Hot junction reduces charge current
// - Default input limit from detected source type
// - Input limit zeroes charge, then battery supplements
`default_nettype none
package chg_pkg;

  // Clock and timing
  localparam int CLK_NS        = 40;
  localparam int INT_PULSE_NS  = 256000;
  localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_NS;
  localparam int BLINK_HALF_NS = 500000000;
  localparam int BLINK_CYC     = BLINK_HALF_NS / CLK_NS;
  localparam int SHIP_MIN_NS   = 2000000;
  localparam int SHIP_MIN_CYC  = (SHIP_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W         = 24;

  // Register byte offsets
  localparam logic [7:0] OFS_SRC   = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_ICLR  = 8'h10;
  localparam logic [7:0] OFS_IEN   = 8'h14;
  localparam logic [7:0] OFS_SHIP  = 8'h18;

  // Reset values and fields
  localparam logic [7:0] SRC_RST     = 8'h58;
  localparam logic [7:0] CFG_RST     = 8'h3b;
  localparam int         CFG_BOOST   = 5;
  localparam logic [1:0] CFG_CHG_ON  = 2'h1;
  localparam int         INPUT_LIMIT_RESISTOR_PIN_W      = 3;
  localparam int         SHIP_BIT    = 0;

  // Interrupt status bits
  localparam int IRQ_FAULT  = 0;
  localparam int IRQ_STATUS = 1;
  localparam int IRQ_DONE   = 2;
  localparam int IRQ_SHIP   = 3;
  localparam int IRQ_W      = 4;

  // Charge cycle phases
  typedef enum logic [2:0] {
    PH_IDLE, PH_PRE, PH_CC, PH_CV, PH_DONE
  } chg_phase_t;

  // Synchronised pin inputs
  typedef struct packed {
    logic              boost_req;
    logic              ce_n;
    logic              ship_exit;
    logic              vbus;
    logic              bat_low;
    logic              bat_cv;
    logic              bat_rechg;
    logic              term;
    logic              ts_bad;
    logic              tj_hot;
    logic              in_limit;
    logic              load_over;
    logic              fault;
    logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] res_lim;
    logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] src_type;
  } chg_pins_t;

  // Whole state of the controller
  typedef struct packed {
    chg_phase_t        phase;
    logic [7:0]        src_reg;
    logic [7:0]        cfg_reg;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_en;
    logic              irq;
    logic              ship;
    logic              ship_prev;
    logic              ship_arm;
    logic [CNT_W-1:0]  ship_cnt;
    logic [CNT_W-1:0]  blink_cnt;
    logic              blink;
    logic [CNT_W-1:0]  int_cnt;
    logic              int_oe;
    logic              stat_oe;
    logic              fault_prev;
    logic              vbus_prev;
    logic              chg;
    logic              boost;
    logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] input_limit_resistor_pin;
    logic              ich_red;
    logic              ich_zero;
    logic              supp;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } chg_state_t;

endpackage
`default_nettype wire

// [rtl/chg_sync.sv]
// Two-flop synchroniser for a vector of pin levels.
// Assumes rst_n is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module chg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;  // First stage, read only by second

  // Two stages, cleared at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // chg_sync
`default_nettype wire

// [rtl/chg_ctl.sv]
// Charger control and status logic with APB register slave.
// Assumes analog comparators deliver digital levels on the pins.
`timescale 1ns/1ps
`default_nettype none
module chg_ctl #(
  parameter int INT_CYC   = chg_pkg::INT_PULSE_CYC,
  parameter int BLINK_HC  = chg_pkg::BLINK_CYC,
  parameter int SHIP_CYC  = chg_pkg::SHIP_MIN_CYC
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       NRST,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [7:0]                 PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  input  wire logic                       BOOST_REQ,
  input  wire logic                       CHG_EN_N,
  input  wire logic                       SHIP_EXIT,
  input  wire logic                       VBUS_OK,
  input  wire logic                       BAT_LOW,
  input  wire logic                       BAT_CV,
  input  wire logic                       BAT_RECHG,
  input  wire logic                       ICHG_TERM,
  input  wire logic                       TS_BAD,
  input  wire logic                       TJ_HOT,
  input  wire logic                       IN_LIMIT,
  input  wire logic                       LOAD_OVER,
  input  wire logic                       FAULT,
  input  wire logic [chg_pkg::INPUT_LIMIT_RESISTOR_PIN_W-1:0] RES_LIM,
  input  wire logic [chg_pkg::INPUT_LIMIT_RESISTOR_PIN_W-1:0] SRC_TYPE,
  output logic                            STAT_O,
  output logic                            STAT_OE,
  output logic                            INT_O,
  output logic                            INT_OE,
  output logic                            IRQ,
  output logic                            CHG_ON,
  output logic                            BOOST_ON,
  output logic                            BATT_SW_ON,
  output logic [chg_pkg::INPUT_LIMIT_RESISTOR_PIN_W-1:0]      INPUT_LIMIT_RESISTOR_PIN_EFF,
  output logic                            ICHG_REDUCE,
  output logic                            ICHG_ZERO,
  output logic                            SUPPLEMENT,
  output logic [2:0]                      PHASE
);
  import chg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations and helpers

  logic [1:0] rst_sync_q;  // Reset release chain
  logic       rst_n;       // Synchronised reset
  chg_pins_t  pins_raw;    // Pins before sync
  chg_pins_t  pins;        // Pins after sync
  chg_state_t q;           // Registered state
  chg_state_t d;           // Next state
  logic       acc;         // APB access phase
  logic       wr;          // Write taking effect
  logic       setup;       // APB setup phase
  logic       en;          // Charge enabled
  logic       chg_act;     // Charging in progress
  logic       fault_rise;  // New fault
  logic       stchg;       // Phase changed

  // Lower of two limit codes
  function automatic logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] lim_min(
    input logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] a,
    input logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] b
  );
    lim_min = (a < b) ? a : b;
  endfunction

  // Phase counts as charging
  function automatic logic is_active(input chg_phase_t ph);
    is_active = (ph == PH_PRE) || (ph == PH_CC) || (ph == PH_CV);
  endfunction

  // Register is mapped
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_SRC) || (a == OFS_CFG) || (a == OFS_STAT) ||
             (a == OFS_ISTAT) || (a == OFS_ICLR) || (a == OFS_IEN) ||
             (a == OFS_SHIP);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisation

  // Release reset through two flops
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Gather pins for the synchroniser
  always_comb begin
    pins_raw = '{BOOST_REQ, CHG_EN_N, SHIP_EXIT, VBUS_OK, BAT_LOW,
                 BAT_CV, BAT_RECHG, ICHG_TERM, TS_BAD, TJ_HOT,
                 IN_LIMIT, LOAD_OVER, FAULT, RES_LIM, SRC_TYPE};
  end

  chg_sync #(.W($bits(chg_pins_t))) u_sync (
    .clk   (SYS_CLK),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    d          = q;
    setup      = PSEL & ~PENABLE;
    acc        = PSEL & PENABLE & q.pready;
    wr         = acc & PWRITE;
    en         = (q.cfg_reg[5:4] == CFG_CHG_ON) & ~pins.ce_n;
    fault_rise = pins.fault & ~q.fault_prev;

    // APB answer in the access cycle
    d.pready  = setup;
    d.pslverr = setup & ~mapped(PADDR);
    d.prdata  = '0;
    if (setup && !PWRITE) begin
      case (PADDR)
        OFS_SRC:   d.prdata = {24'h0, q.src_reg};
        OFS_CFG:   d.prdata = {24'h0, q.cfg_reg};
        OFS_STAT:  d.prdata = {23'h0, q.supp, q.ship, pins.fault,
                               q.boost, q.chg, q.input_limit_resistor_pin[0], q.phase};
        OFS_ISTAT: d.prdata = {28'h0, q.irq_st};
        OFS_IEN:   d.prdata = {28'h0, q.irq_en};
        default:   d.prdata = '0;
      endcase
    end

    // Register writes
    if (wr) begin
      case (PADDR)
        OFS_SRC:  d.src_reg = PWDATA[7:0];
        OFS_CFG:  d.cfg_reg = PWDATA[7:0];
        OFS_IEN:  d.irq_en  = PWDATA[IRQ_W-1:0];
        OFS_ICLR: d.irq_st  = q.irq_st & ~PWDATA[IRQ_W-1:0];
        OFS_SHIP: d.ship    = q.ship | PWDATA[SHIP_BIT];
        default:  ;
      endcase
    end

    // Source type sets default limit
    d.vbus_prev = pins.vbus;
    if (pins.vbus && !q.vbus_prev) begin
      d.src_reg[INPUT_LIMIT_RESISTOR_PIN_W-1:0] = pins.src_type;
    end

    // Charge cycle sequencing
    case (q.phase)
      PH_IDLE: begin
        if (pins.bat_low) begin
          d.phase = PH_PRE;
        end else if (pins.bat_cv) begin
          d.phase = PH_CV;
        end else begin
          d.phase = PH_CC;
        end
      end
      PH_PRE: begin
        if (!pins.bat_low) begin
          d.phase = PH_CC;
        end
      end
      PH_CC: begin
        if (pins.bat_cv) begin
          d.phase = PH_CV;
        end
      end
      PH_CV: begin
        if (pins.term) begin
          d.phase = PH_DONE;
        end
      end
      PH_DONE: begin
        if (pins.bat_rechg) begin
          d.phase = pins.bat_low ? PH_PRE : PH_CC;
        end
      end
      default: d.phase = PH_IDLE;
    endcase
    if (!en || !pins.vbus || q.ship) begin
      d.phase = PH_IDLE;
    end
    stchg = (d.phase != q.phase);

    // Charging suspends on thermistor
    chg_act = is_active(d.phase) & ~pins.ts_bad;
    d.chg   = chg_act;
    d.boost = pins.boost_req & q.cfg_reg[CFG_BOOST] & ~pins.vbus &
              ~pins.ts_bad & ~q.ship;

    // Current limit and regulation flags
    d.input_limit_resistor_pin     = lim_min(pins.res_lim, q.src_reg[INPUT_LIMIT_RESISTOR_PIN_W-1:0]);
    d.ich_red  = pins.tj_hot & chg_act;
    d.ich_zero = pins.in_limit & chg_act;
    d.supp     = pins.in_limit & pins.load_over;

    // Shipping exit qualification
    d.ship_prev = pins.ship_exit;
    if (!q.ship || !pins.ship_exit) begin
      d.ship_arm = 1'b0;
      d.ship_cnt = '0;
    end else if (!q.ship_prev) begin
      d.ship_arm = 1'b1;
      d.ship_cnt = '0;
    end else if (q.ship_arm) begin
      if (q.ship_cnt == CNT_W'(SHIP_CYC - 1)) begin
        d.ship     = 1'b0;
        d.ship_arm = 1'b0;
      end else begin
        d.ship_cnt = q.ship_cnt + 1'b1;
      end
    end

    // Fault blink divider
    d.fault_prev = pins.fault;
    if (!pins.fault) begin
      d.blink_cnt = '0;
      d.blink     = 1'b0;
    end else if (q.blink_cnt == CNT_W'(BLINK_HC - 1)) begin
      d.blink_cnt = '0;
      d.blink     = ~q.blink;
    end else begin
      d.blink_cnt = q.blink_cnt + 1'b1;
    end
    d.stat_oe = pins.fault ? d.blink : chg_act;

    // Interrupt pulse timer
    if (fault_rise || stchg) begin
      d.int_oe  = 1'b1;
      d.int_cnt = '0;
    end else if (q.int_oe) begin
      if (q.int_cnt == CNT_W'(INT_CYC - 1)) begin
        d.int_oe = 1'b0;
      end else begin
        d.int_cnt = q.int_cnt + 1'b1;
      end
    end

    // Sticky events, set beats clear
    if (fault_rise) d.irq_st[IRQ_FAULT] = 1'b1;
    if (stchg) d.irq_st[IRQ_STATUS] = 1'b1;
    if (stchg && d.phase == PH_DONE) d.irq_st[IRQ_DONE] = 1'b1;
    if (q.ship && !d.ship) d.irq_st[IRQ_SHIP] = 1'b1;
    d.irq = |(d.irq_st & d.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.phase   <= PH_IDLE;
      q.src_reg <= SRC_RST;
      q.cfg_reg <= CFG_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state; STAT_O and INT_O tied low
  assign PRDATA      = q.prdata;
  assign PREADY      = q.pready;
  assign PSLVERR     = q.pslverr;
  assign STAT_O      = 1'b0;
  assign STAT_OE     = q.stat_oe;
  assign INT_O       = 1'b0;
  assign INT_OE      = q.int_oe;
  assign IRQ         = q.irq;
  assign CHG_ON      = q.chg;
  assign BOOST_ON    = q.boost;
  assign BATT_SW_ON  = ~q.ship;
  assign INPUT_LIMIT_RESISTOR_PIN_EFF    = q.input_limit_resistor_pin;
  assign ICHG_REDUCE = q.ich_red;
  assign ICHG_ZERO   = q.ich_zero;
  assign SUPPLEMENT  = q.supp;
  assign PHASE       = q.phase;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  sequence fault_start_s;
    pins.fault && !q.fault_prev;
  endsequence

  sequence cv_term_s;
    q.phase == PH_CV && pins.term && en && pins.vbus && !q.ship;
  endsequence

  stat_level_a: assert property ($past(!pins.fault) |-> q.stat_oe == q.chg)
    else $error("status level does not follow charging");
  blink_tog_a: assert property (pins.fault && q.blink_cnt == CNT_W'(BLINK_HC - 1)
    ##1 pins.fault |-> q.blink != $past(q.blink))
    else $error("blink did not toggle");
  int_pulse_a: assert property (fault_start_s |=> q.int_oe [*8])
    else $error("interrupt pulse missing");
  int_len_a: assert property ($fell(q.int_oe) |-> $past(q.int_cnt) == CNT_W'(INT_CYC - 1))
    else $error("interrupt pulse wrong length");
  boost_cond_a: assert property (q.boost |-> $past(pins.boost_req
    && q.cfg_reg[CFG_BOOST] && !pins.vbus))
    else $error("boost without its conditions");
  chg_cond_a: assert property (q.chg |-> $past(q.cfg_reg[5:4] == CFG_CHG_ON
    && !pins.ce_n))
    else $error("charging without enable");
  input_limit_resistor_pin_min_a: assert property (q.input_limit_resistor_pin <= $past(pins.res_lim)
    && q.input_limit_resistor_pin <= $past(q.src_reg[INPUT_LIMIT_RESISTOR_PIN_W-1:0]))
    else $error("limit is not the lower one");
  ship_exit_a: assert property ($fell(q.ship) |-> $past(pins.ship_exit)
    && $past(q.ship_cnt) == CNT_W'(SHIP_CYC - 1))
    else $error("ship exit without hold time");
  pre_pick_a: assert property (q.phase == PH_IDLE && en && pins.vbus
    && !q.ship && pins.bat_low |=> q.phase == PH_PRE)
    else $error("precharge phase not chosen");
  cv_term_a: assert property (cv_term_s |=> q.phase == PH_DONE)
    else $error("no termination in CV phase");
  rechg_a: assert property (q.phase == PH_DONE && pins.bat_rechg && en
    && pins.vbus && !q.ship |=> is_active(q.phase))
    else $error("no recharge");
  ts_susp_a: assert property (pins.ts_bad |=> !q.chg && !q.boost)
    else $error("thermistor fault not obeyed");
  therm_red_a: assert property (q.ich_red |-> $past(pins.tj_hot))
    else $error("reduction without hot junction");
  src_def_a: assert property ($rose(pins.vbus) |=>
    q.src_reg[INPUT_LIMIT_RESISTOR_PIN_W-1:0] == $past(pins.src_type))
    else $error("default limit not loaded");
  supp_a: assert property (pins.in_limit && pins.load_over |=> q.supp)
    else $error("supplement not entered");
  fault_pri_a: assert property ($past(pins.fault) |-> q.stat_oe == q.blink)
    else $error("fault blink not in control");
endmodule // chg_ctl
`default_nettype wire

// [tb/chg_board.sv]
// Board side model of the charger pins.
// Assumes the design drives open-drain pins through output enables.
`timescale 1ns/1ps
`default_nettype none
module chg_board (
  input  wire logic stat_o,    // Status pin level when driven
  input  wire logic stat_oe,   // Status pin drive enable
  input  wire logic int_o,     // Interrupt pin level when driven
  input  wire logic int_oe,    // Interrupt pin drive enable
  input  wire logic ce_req,    // Host wish for the enable pin
  output logic      stat_line, // Resolved status wire
  output logic      int_line,  // Resolved interrupt wire
  output logic      ce_n       // Charge enable pin, active low
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pull-ups win whenever the design releases a pin
  assign stat_line = stat_oe ? stat_o : 1'b1;
  assign int_line  = int_oe ? int_o : 1'b1;
  // Strap resolves any unknown request to the disabled level
  assign ce_n = (ce_req === 1'b0) ? 1'b0 : 1'b1;
endmodule // chg_board
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the charger control logic.
// Assumes pins pass a short synchroniser; APB waits on pready however long.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import chg_pkg::*;
  localparam int INT_C = 16; // Short interrupt pulse
  localparam int BLINK_C = 20; // Short blink half period
  localparam int SHIP_C = 10; // Short ship exit hold
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, stat_o, stat_oe, int_o, int_oe, irq, chg_on, boost_on;
  logic batt_sw_on, ichg_reduce, ichg_zero, supplement, stat_line, int_line, ce_n;
  logic boost_req = 0, ce_req = 0, ship_exit = 0, vbus_ok = 0, bat_low = 1, bat_cv = 0;
  logic bat_rechg = 0, ichg_term = 0, ts_bad = 0, tj_hot = 0, in_limit = 0;
  logic load_over = 0, fault = 0, v;
  logic [INPUT_LIMIT_RESISTOR_PIN_W-1:0] res_lim = 3'h7, src_type = 3'h5, input_limit_resistor_pin_eff;
  logic [2:0] phase;
  int err_count = 0, compares = 0, n, m;
  ////////////////////////////////////////////////////////////////////////////////
  chg_ctl #(.INT_CYC(INT_C), .BLINK_HC(BLINK_C), .SHIP_CYC(SHIP_C)) u_dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BOOST_REQ(boost_req), .CHG_EN_N(ce_n), .SHIP_EXIT(ship_exit), .VBUS_OK(vbus_ok),
    .BAT_LOW(bat_low), .BAT_CV(bat_cv), .BAT_RECHG(bat_rechg), .ICHG_TERM(ichg_term),
    .TS_BAD(ts_bad), .TJ_HOT(tj_hot), .IN_LIMIT(in_limit), .LOAD_OVER(load_over),
    .FAULT(fault), .RES_LIM(res_lim), .SRC_TYPE(src_type), .STAT_O(stat_o),
    .STAT_OE(stat_oe), .INT_O(int_o), .INT_OE(int_oe), .IRQ(irq), .CHG_ON(chg_on),
    .BOOST_ON(boost_on), .BATT_SW_ON(batt_sw_on), .INPUT_LIMIT_RESISTOR_PIN_EFF(input_limit_resistor_pin_eff),
    .ICHG_REDUCE(ichg_reduce), .ICHG_ZERO(ichg_zero), .SUPPLEMENT(supplement),
    .PHASE(phase));
  chg_board u_board (.stat_o(stat_o), .stat_oe(stat_oe), .int_o(int_o), .int_oe(int_oe),
    .ce_req(ce_req), .stat_line(stat_line), .int_line(int_line), .ce_n(ce_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #(40 * 20000);
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Next rising edge, where pins are driven
  task automatic step();
    @(posedge sys_clk);
  endtask
  // Let pins pass the sync flops, then sample at a falling edge
  task automatic settle();
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // One APB transfer; the answer is taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(OFS_SRC, 32'h58);
    rdc(OFS_CFG, 32'h3b);
    rdc(8'h1c, 32'h0);
    chk1(er, 1'b1);
    wr(OFS_ISTAT, 32'hf);
    rdc(OFS_ISTAT, 32'h0);
    // Boost condition table, then thermistor veto
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CFG, i[1] ? 32'h3b : 32'h1b);
      boost_req <= i[0];
      vbus_ok <= i[2];
      settle();
      chk1(boost_on, i[0] & i[1] & !i[2]);
    end
    step();
    vbus_ok <= 1'b0;
    ts_bad <= 1'b1;
    settle();
    chk1(boost_on, 1'b0);
    step();
    ts_bad <= 1'b0;
    boost_req <= 1'b0;
    vbus_ok <= 1'b1;
    settle();
    rdc(OFS_SRC, 32'h5d);
    // Effective input limit is the smaller code
    for (int s = 0; s < 8; s++) begin
      for (int r = 0; r < 8; r++) begin
        wr(OFS_SRC, {24'h0, 5'h0b, 3'(s)});
        res_lim <= 3'(r);
        settle();
        chk(32'(input_limit_resistor_pin_eff), (r < s) ? r : s);
      end
    end
    // Enable gating and status pin level
    wr(OFS_CFG, 32'h1b);
    settle();
    chk(32'(phase), 32'h1);
    chk1(chg_on, 1'b1);
    chk1(stat_line, 1'b0);
    step();
    ce_req <= 1'b1;
    settle();
    chk1(chg_on, 1'b0);
    chk1(stat_line, 1'b1);
    step();
    ce_req <= 1'b0;
    ts_bad <= 1'b1;
    settle();
    chk1(chg_on, 1'b0);
    step();
    ts_bad <= 1'b0;
    wr(OFS_CFG, 32'h2b);
    settle();
    chk1(chg_on, 1'b0);
    wr(OFS_CFG, 32'h1b);
    // Autonomous phase walk with termination and recharge
    step();
    bat_low <= 1'b0;
    settle();
    chk(32'(phase), 32'h2);
    step();
    bat_cv <= 1'b1;
    settle();
    chk(32'(phase), 32'h3);
    step();
    ichg_term <= 1'b1;
    settle();
    chk(32'(phase), 32'h4);
    chk1(stat_line, 1'b1);
    apb(1'b0, OFS_ISTAT, 32'h0, rd, er);
    chk1(rd[IRQ_DONE], 1'b1);
    step();
    bat_cv <= 1'b0;
    ichg_term <= 1'b0;
    bat_rechg <= 1'b1;
    settle();
    chk(32'(phase), 32'h2);
    step();
    bat_rechg <= 1'b0;
    // Fault pulse, blink override and interrupt masking
    wr(OFS_ICLR, 32'hf);
    wr(OFS_IEN, 32'h1);
    repeat (40) @(posedge sys_clk);
    fault <= 1'b1;
    n = 0;
    while (int_line !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    m = 0;
    while (int_line === 1'b0 && m < 60) begin
      @(negedge sys_clk);
      m++;
    end
    chk(m, INT_C);
    v = stat_line;
    n = 0;
    while (stat_line === v && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    v = stat_line;
    m = 0;
    while (stat_line === v && m < 60) begin
      @(negedge sys_clk);
      m++;
    end
    chk(m, BLINK_C);
    chk1(irq, 1'b1);
    wr(OFS_IEN, 32'h0);
    settle();
    chk1(irq, 1'b0);
    wr(OFS_IEN, 32'h1);
    wr(OFS_ICLR, 32'h1);
    settle();
    chk1(irq, 1'b0);
    step();
    fault <= 1'b0;
    repeat (BLINK_C + 2) @(posedge sys_clk);
    settle();
    chk1(stat_line, 1'b0);
    // Thermal regulation and power path limits
    step();
    tj_hot <= 1'b1;
    in_limit <= 1'b1;
    load_over <= 1'b1;
    settle();
    chk1(ichg_reduce, 1'b1);
    chk1(ichg_zero, 1'b1);
    chk1(supplement, 1'b1);
    step();
    tj_hot <= 1'b0;
    in_limit <= 1'b0;
    load_over <= 1'b0;
    settle();
    chk1(ichg_zero, 1'b0);
    // Shipping mode exit needs a held high level
    wr(OFS_SHIP, 32'h1);
    settle();
    chk1(batt_sw_on, 1'b0);
    step();
    ship_exit <= 1'b1;
    repeat (SHIP_C - 4) @(posedge sys_clk);
    ship_exit <= 1'b0;
    settle();
    chk1(batt_sw_on, 1'b0);
    step();
    ship_exit <= 1'b1;
    repeat (SHIP_C) @(posedge sys_clk);
    @(negedge sys_clk);
    chk1(batt_sw_on, 1'b0);
    n = 0;
    while (batt_sw_on !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk1(batt_sw_on, 1'b1);
    apb(1'b0, OFS_ISTAT, 32'h0, rd, er);
    chk1(rd[IRQ_SHIP], 1'b1);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
